/* File: logic/fmrm_pkg.sv */
package fmrm_pkg;
    // ==========================================================
    // Bus pins, carried together
    // ==========================================================
    typedef struct packed {
        logic        sel_n;
        logic        rd_n;
        logic        wr_n;
        logic [11:0] addr;
        logic [7:0]  data;
    } fmrm_bus_type;

    // ==========================================================
    // Global map
    // ==========================================================
    localparam logic [11:0] ADDR_NOTEBOOK   = 12'h004;
    localparam logic [11:0] ADDR_RESET_KEY  = 12'h005;
    localparam logic [11:0] ADDR_GLOB_CFG   = 12'h006;
    localparam logic [11:0] ADDR_GLOB_TAIL  = 12'h0FF;
    localparam logic [7:0]  RESET_KEY_VALUE = 8'h91;
    localparam logic [7:0]  RESET_KEY_HELD  = 8'h01;
    localparam logic [7:0]  RESET_KEY_IDLE  = 8'h00;
    localparam logic [7:0]  GLOB_CFG_MASK   = 8'hF9;
    localparam logic [7:0]  GLOB_TAIL_MASK  = 8'h10;
    localparam logic [7:0]  REG_RESET_VALUE = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

    // ==========================================================
    // Per-channel map (offset within channel page)
    // ==========================================================
    localparam logic [7:0] OFF_MODE_LAST   = 8'h04;
    localparam logic [7:0] OFF_CHAN_RESET  = 8'h05;
    localparam logic [7:0] OFF_INT_MASK    = 8'h09;
    localparam logic [7:0] OFF_PERF_COUNT  = 8'h20;
    localparam logic [7:0] OFF_RAM_FIRST   = 8'h40;
    localparam int         SOFT_RESET_BIT  = 7;
    localparam int         POWER_EN_REG    = 1;
    localparam int         POWER_EN_BIT    = 4;
    localparam int         MODE_REG_COUNT  = 5;
    localparam int         SYNC_STAGES     = 2;
endpackage : fmrm_pkg

/* File: logic/fmrm_reset_map.sv */
`timescale 1ns/1ps
// Contract
// [R1] Host holds reset pin low at least 10 clocks after clocks settle.
// [R2] Hardware reset clears channel registers at offsets below X40H.
// [R3] Hardware reset clears global registers 004H through 0FFH.
// [R4] Global soft reset clears counters and state, keeps control registers.
// [R5] Writing 91H to byte 005H enters global soft reset.
// [R6] Writing any other value to 005H leaves global soft reset.
// [R7] Reading 005H returns 01H in soft reset, else 00H.
// [R8] Host writes 1 then 0 to X05H bit 7; channel resets.
// [R9] Channel RAM X40H to XFFH survives hardware and soft resets.
// [R10] Host issues global soft reset no sooner than 40 ms after power-up.
// [R11] Host follows mode bit changes in X00H to X04H by channel reset.
// [R12] Host must channel-reset after frame mode select bits change.
// [R13] Host reprograms channel RAM controls after frame mode change.
// [R14] Host powers down unused channels and masks their interrupts.
// [R15] Host never accesses spare or unlisted addresses.
// [R16] Locations behave per class: read-only, latched, write-only, read/write.
// [R17] Reserved read-only bits read fixed values or indeterminate.
// [R18] Reserved read/write bits without storage do not read back.
// [R19] Host writes 0 to stored reserved bits, never holds data there.
// [R20] While channel reset bit is 1, channel counters stay reset.
module fmrm_reset_map #(
    parameter int CHANNELS  = 4,
    parameter int RAM_WORDS = 1024
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 reset_n_pin_i,
    input  wire fmrm_pkg::fmrm_bus_type bus_i,
    output logic [7:0]                data_o,
    output logic                      data_oe_o,
    output logic                      soft_reset_o,
    output logic [CHANNELS-1:0]       channel_in_reset_o
);
    import fmrm_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    fmrm_bus_type                  bus_meta;
    fmrm_bus_type                  bus_s;
    logic [SYNC_STAGES-1:0]        rst_pin_s;
    logic                          wr_prev;

    always_ff @(posedge sys_clk_i) begin
        bus_meta  <= bus_i;
        bus_s     <= bus_meta;
        rst_pin_s <= {rst_pin_s[0], reset_n_pin_i};
        wr_prev   <= bus_s.wr_n;
    end

    // Pin low for any sync'd cycle resets; hold length is the host's duty
    logic hw_rst;                                   // see [R1]
    logic wr_stb;
    logic rd_act;
    logic glob_hit;
    logic chan_hit;
    logic [1:0] chan_sel;
    logic [7:0] off;

    always_comb begin
        hw_rst   = rst_i || !rst_pin_s[1];
        wr_stb   = !bus_s.sel_n && wr_prev && !bus_s.wr_n;
        rd_act   = !bus_s.sel_n && !bus_s.rd_n;
        glob_hit = bus_s.addr[11:8] == 4'h0;
        chan_hit = bus_s.addr[11:8] >= 4'h1
                   && {28'h0, bus_s.addr[11:8]} <= CHANNELS;
        chan_sel = 2'(bus_s.addr[11:8] - 4'h1);
        off      = bus_s.addr[7:0];
    end

    // ==========================================================
    // Global registers
    // ==========================================================
    logic [7:0] notebook;
    logic [7:0] glob_cfg;
    logic [7:0] glob_tail;
    logic       soft_rst;
    logic [7:0] next_notebook;
    logic [7:0] next_glob_cfg;
    logic [7:0] next_glob_tail;
    logic       next_soft_rst;

    always_comb begin
        next_notebook  = notebook;
        next_glob_cfg  = glob_cfg;
        next_glob_tail = glob_tail;
        next_soft_rst  = soft_rst;
        if (wr_stb) begin
            case (bus_s.addr)
                ADDR_NOTEBOOK:  next_notebook = bus_s.data;
                ADDR_RESET_KEY: begin
                    next_soft_rst = bus_s.data == RESET_KEY_VALUE; // see [R5] see [R6]
                end
                // Bits without storage are dropped on write
                ADDR_GLOB_CFG:  next_glob_cfg = bus_s.data & GLOB_CFG_MASK; // see [R18]
                ADDR_GLOB_TAIL: next_glob_tail = bus_s.data & GLOB_TAIL_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (hw_rst) begin                           // see [R3]
            notebook  <= REG_RESET_VALUE;
            glob_cfg  <= REG_RESET_VALUE;
            glob_tail <= REG_RESET_VALUE;
            soft_rst  <= 1'b0;
        end else begin
            notebook  <= next_notebook;
            glob_cfg  <= next_glob_cfg;
            glob_tail <= next_glob_tail;
            soft_rst  <= next_soft_rst;
        end
    end

    // ==========================================================
    // Per-channel control, counters and RAM
    // ==========================================================
    logic [7:0] mode_reg  [CHANNELS][MODE_REG_COUNT];
    logic [7:0] chan_ctl  [CHANNELS];
    logic [7:0] int_mask  [CHANNELS];
    logic [7:0] perf_cnt  [CHANNELS];
    logic [7:0] chan_ram  [RAM_WORDS];
    logic       ram_we;

    // RAM is never reset, so contents ride through every reset
    always_comb begin
        ram_we = wr_stb && chan_hit && off >= OFF_RAM_FIRST;
    end

    always_ff @(posedge sys_clk_i) begin
        if (ram_we) begin                           // see [R9]
            chan_ram[{chan_sel, off}] <= bus_s.data;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            logic       wr_ch;
            logic       ch_rst;
            logic [7:0] next_mode [MODE_REG_COUNT];
            logic [7:0] next_ctl;
            logic [7:0] next_mask;
            logic [7:0] next_cnt;

            always_comb begin
                wr_ch     = wr_stb && chan_hit && chan_sel == 2'(g);
                // Counter clears on either reset kind, control does not
                ch_rst    = soft_rst || chan_ctl[g][SOFT_RESET_BIT]; // see [R4] see [R8] see [R20]
                next_mode = mode_reg[g];
                next_ctl  = chan_ctl[g];
                next_mask = int_mask[g];
                if (wr_ch && off <= OFF_MODE_LAST) begin
                    next_mode[off[2:0]] = bus_s.data;
                end
                if (wr_ch && off == OFF_CHAN_RESET) begin
                    next_ctl = bus_s.data;
                end
                if (wr_ch && off == OFF_INT_MASK) begin
                    next_mask = bus_s.data;
                end
                if (ch_rst) begin
                    next_cnt = 8'h00;
                end else if (mode_reg[g][POWER_EN_REG][POWER_EN_BIT]) begin
                    next_cnt = perf_cnt[g] + 8'h01;
                end else begin
                    next_cnt = perf_cnt[g];
                end
            end

            always_ff @(posedge sys_clk_i) begin
                if (hw_rst) begin                   // see [R2]
                    for (int r = 0; r < MODE_REG_COUNT; r++) begin
                        mode_reg[g][r] <= REG_RESET_VALUE;
                    end
                    chan_ctl[g]              <= REG_RESET_VALUE;
                    int_mask[g]              <= REG_RESET_VALUE;
                    perf_cnt[g]              <= 8'h00;
                    channel_in_reset_o[g]    <= 1'b0;
                end else begin
                    mode_reg[g]              <= next_mode;
                    chan_ctl[g]              <= next_ctl;
                    int_mask[g]              <= next_mask;
                    perf_cnt[g]              <= next_cnt;
                    channel_in_reset_o[g]    <= ch_rst;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read path
    // ==========================================================
    logic [7:0] rd_val;

    always_comb begin
        rd_val = UNMAPPED_READ;                     // see [R16] see [R17]
        if (glob_hit) begin
            case (bus_s.addr)
                ADDR_NOTEBOOK:  rd_val = notebook;
                ADDR_RESET_KEY: begin
                    rd_val = soft_rst ? RESET_KEY_HELD : RESET_KEY_IDLE; // see [R7]
                end
                ADDR_GLOB_CFG:  rd_val = glob_cfg;
                ADDR_GLOB_TAIL: rd_val = glob_tail;
                default:        rd_val = UNMAPPED_READ;
            endcase
        end else if (chan_hit) begin
            if (off >= OFF_RAM_FIRST) begin
                rd_val = chan_ram[{chan_sel, off}];
            end else if (off <= OFF_MODE_LAST) begin
                rd_val = mode_reg[chan_sel][off[2:0]];
            end else if (off == OFF_CHAN_RESET) begin
                rd_val = chan_ctl[chan_sel];
            end else if (off == OFF_INT_MASK) begin
                rd_val = int_mask[chan_sel];
            end else if (off == OFF_PERF_COUNT) begin
                rd_val = perf_cnt[chan_sel];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            data_o       <= 8'h00;
            data_oe_o    <= 1'b0;
            soft_reset_o <= 1'b0;
        end else begin
            data_o       <= rd_val;
            data_oe_o    <= rd_act;
            soft_reset_o <= soft_rst;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    key_enter_a: assert property (wr_stb && bus_s.addr == ADDR_RESET_KEY
        && bus_s.data == RESET_KEY_VALUE && !hw_rst |=> ##1 soft_reset_o) // see [R5]
        else $error("soft reset not entered on key");
    key_leave_a: assert property (wr_stb && bus_s.addr == ADDR_RESET_KEY
        && bus_s.data != RESET_KEY_VALUE |=> ##1 !soft_reset_o) // see [R6]
        else $error("soft reset not left");
    key_read_a: assert property (rd_act && bus_s.addr == ADDR_RESET_KEY
        |=> data_o == {7'h00, $past(soft_rst)}) // see [R7]
        else $error("reset byte read wrong");
    glob_clear_a: assert property (hw_rst |=> notebook == 8'h00
        && glob_cfg == 8'h00 && !soft_rst) // see [R3]
        else $error("global registers not cleared");
    chan_clear_a: assert property (hw_rst |=> chan_ctl[0] == 8'h00
        && int_mask[0] == 8'h00 && mode_reg[0][1] == 8'h00) // see [R2]
        else $error("channel registers not cleared");
    soft_keep_a: assert property (soft_rst && !hw_rst && !wr_stb
        |=> $stable(mode_reg[0][1]) && perf_cnt[0] == 8'h00) // see [R4]
        else $error("soft reset touched control or kept count");
    chan_hold_a: assert property (chan_ctl[0][SOFT_RESET_BIT] [*2]
        |-> perf_cnt[0] == 8'h00 && channel_in_reset_o[0]) // see [R20]
        else $error("channel counter ran while held");
    // Case equality: the word may still be unwritten at the first reset
    ram_keep_a: assert property (hw_rst && !ram_we
        |=> chan_ram[64] === $past(chan_ram[64])) // see [R9]
        else $error("channel memory lost on reset");
    cfg_hole_a: assert property (glob_cfg[2:1] == 2'b00) // see [R18]
        else $error("reserved bits hold a value");
    notebook_read_a: assert property (rd_act && bus_s.addr == ADDR_NOTEBOOK
        |=> data_oe_o && data_o == $past(notebook)) // see [R16]
        else $error("notebook read returned wrong data");

    enter_soft_c: cover property (!soft_rst ##1 soft_rst);
    chan_pulse_c: cover property (channel_in_reset_o[0] ##[1:20]
        !channel_in_reset_o[0]);
    ram_read_c:   cover property (rd_act && chan_hit
        && off >= OFF_RAM_FIRST);
endmodule : fmrm_reset_map

/* File: testbench/fmrm_host_model.sv */
`timescale 1ns/1ps
module fmrm_host_model (
    input  wire logic              sys_clk_i,
    output fmrm_pkg::fmrm_bus_type bus_o,
    output logic                   reset_n_pin_o
);
    import fmrm_pkg::*;
    logic [7:0] exp_q[$];

    initial begin
        bus_o = '{1'b1, 1'b1, 1'b1, 12'h000, 8'h00};
        reset_n_pin_o = 1'b1;
    end

    // ==========================================================
    // Hardware reset pin
    // ==========================================================
    task automatic hw_reset(input int cycles);
        @(negedge sys_clk_i);
        reset_n_pin_o = 1'b0;
        repeat (cycles) @(negedge sys_clk_i);
        reset_n_pin_o = 1'b1;
        // Sync plus edge detector need three edges to settle
        repeat (3) @(negedge sys_clk_i);
    endtask : hw_reset

    // ==========================================================
    // One strobe cycle; there is no ready, so the hold is fixed
    // ==========================================================
    task automatic access(input logic rd, input logic [11:0] a,
                          input logic [7:0] d);
        @(negedge sys_clk_i);
        if (rd) exp_q.push_back(d);
        bus_o.addr  = a;
        bus_o.data  = rd ? ~bus_o.data : d;
        bus_o.sel_n = 1'b0;
        bus_o.rd_n  = !rd;
        bus_o.wr_n  = rd;
        repeat (5) @(negedge sys_clk_i);
        bus_o.sel_n = 1'b1;
        bus_o.rd_n  = 1'b1;
        bus_o.wr_n  = 1'b1;
        // Released lines must not keep showing the old value
        bus_o.addr  = ~a;
        bus_o.data  = ~bus_o.data;
        // Strobe high at least three clocks before the next cycle
        repeat (4) @(negedge sys_clk_i);
    endtask : access
endmodule : fmrm_host_model

/* File: testbench/tb_fmrm_reset_map.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    errors++; $display("Error at %0t ns: got %h expected %h", \
    $time, (got), (exp)); end end
module tb_fmrm_reset_map;
    import fmrm_pkg::*;
    logic         sys_clk_i = 1'b0;
    logic         rst_i     = 1'b1;
    fmrm_bus_type bus;
    logic         reset_n_pin;
    logic [7:0]   data_o;
    logic         data_oe_o;
    logic         soft_reset_o;
    logic [3:0]   chan_rst;
    logic         oe_seen   = 1'b0;
    logic [7:0]   note;
    logic [7:0]   want;
    logic [7:0]   key;
    logic [7:0]   ram_v [1:4];
    int           errors    = 0;
    int           compares  = 0;
    int           cycles    = 0;

    always #50 sys_clk_i = ~sys_clk_i;

    fmrm_reset_map #(.CHANNELS(4), .RAM_WORDS(1024)) fmrm_reset_map_i (
        .sys_clk_i          (sys_clk_i),
        .rst_i              (rst_i),
        .reset_n_pin_i      (reset_n_pin),
        .bus_i              (bus),
        .data_o             (data_o),
        .data_oe_o          (data_oe_o),
        .soft_reset_o       (soft_reset_o),
        .channel_in_reset_o (chan_rst)
    );

    fmrm_host_model fmrm_host_model_i (
        .sys_clk_i     (sys_clk_i),
        .bus_o         (bus),
        .reset_n_pin_o (reset_n_pin)
    );

    // ==========================================================
    // Read watcher: oldest note against each new read answer
    // ==========================================================
    always @(negedge sys_clk_i) begin
        if (data_oe_o === 1'b1 && !oe_seen) begin
            want = fmrm_host_model_i.exp_q.pop_front();
            `CHK(data_o, want)
        end
        oe_seen <= (data_oe_o === 1'b1);
    end

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            $display("Error at %0t ns: timeout", $time);
            close_out();
        end
    end

    task automatic close_out();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        fmrm_host_model_i.access(1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        fmrm_host_model_i.access(1'b1, a, e);
    endtask : rd

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        void'($urandom(32'h82A3BB6C));
        repeat (3) @(negedge sys_clk_i);
        rst_i = 1'b0;
        fmrm_host_model_i.hw_reset(10);
        rd(ADDR_RESET_KEY, RESET_KEY_IDLE);
        rd(ADDR_NOTEBOOK, REG_RESET_VALUE);
        for (logic [3:0] ch = 4'h1; ch <= 4'h4; ch++) begin
            note = 8'($urandom);
            ram_v[ch] = 8'($urandom);
            wr({ch, 8'h00}, note);
            rd({ch, 8'h00}, note);
            wr({ch, OFF_RAM_FIRST}, ram_v[ch]);
        end
        note = 8'($urandom);
        wr(ADDR_NOTEBOOK, note);
        wr(ADDR_GLOB_CFG, 8'hFF);
        rd(ADDR_GLOB_CFG, GLOB_CFG_MASK);
        // Unstored bits of this byte are written as zero, the stored bit as one
        wr(ADDR_GLOB_TAIL, GLOB_TAIL_MASK);
        rd(ADDR_GLOB_TAIL, GLOB_TAIL_MASK);
        // Only mapped locations are touched; unpowered counter stays put
        rd(12'h120, 8'h00);
        wr(12'h101, 8'h10);
        // Power-up wait before the soft reset is shortened to fit the run
        while (cycles < 400) @(negedge sys_clk_i);
        wr(ADDR_RESET_KEY, RESET_KEY_VALUE);
        `CHK(soft_reset_o, 1'b1)
        `CHK(chan_rst, 4'hF)
        rd(ADDR_RESET_KEY, RESET_KEY_HELD);
        rd(12'h120, 8'h00);
        rd(ADDR_NOTEBOOK, note);
        rd(12'h101, 8'h10);
        rd(12'h140, ram_v[1]);
        do key = 8'($urandom); while (key == RESET_KEY_VALUE);
        wr(ADDR_RESET_KEY, key);
        `CHK(soft_reset_o, 1'b0)
        rd(ADDR_RESET_KEY, RESET_KEY_IDLE);
        // Frame mode change, then channel reset and RAM reload
        wr(12'h104, 8'h06);
        wr(12'h105, 8'h80);
        `CHK(chan_rst, 4'h1)
        rd(12'h105, 8'h80);
        rd(12'h120, 8'h00);
        wr(12'h105, 8'h00);
        `CHK(chan_rst, 4'h0)
        ram_v[1] = 8'($urandom);
        wr(12'h140, ram_v[1]);
        wr(12'h401, 8'h00);
        wr(12'h409, 8'hFF);
        rd(12'h409, 8'hFF);
        fmrm_host_model_i.hw_reset(10);
        rd(ADDR_NOTEBOOK, REG_RESET_VALUE);
        for (logic [3:0] ch = 4'h1; ch <= 4'h4; ch++) begin
            rd({ch, 8'h00}, REG_RESET_VALUE);
            rd({ch, OFF_RAM_FIRST}, ram_v[ch]);
        end
        repeat (4) @(negedge sys_clk_i);
        `CHK(fmrm_host_model_i.exp_q.size(), 0)
        close_out();
    end
endmodule : tb_fmrm_reset_map
